// file: logic/gsf_pkg.sv
/*
 gauge shutdown and status flags: register map, field positions, reset values, modes.
 assumes a single 20 MHz system clock and 32-bit word registers on a plain strobe port.
*/
package gsf_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned OT_TIME_UNIT_S = 1; // over-temperature time counts seconds
    localparam int unsigned SEC_CYCLES = CLK_HZ * OT_TIME_UNIT_S;

    // register byte addresses
    localparam logic [7:0] A_PACK  = 8'h00;
    localparam logic [7:0] A_CTRL  = 8'h04;
    localparam logic [7:0] A_FLAGS = 8'h08;
    localparam logic [7:0] A_COT   = 8'h0C;
    localparam logic [7:0] A_DOT   = 8'h10;
    localparam logic [7:0] A_INH   = 8'h14;
    localparam logic [7:0] A_SUSP  = 8'h18;
    localparam logic [7:0] A_CUR   = 8'h1C;
    localparam logic [7:0] A_TAPER = 8'h20;
    localparam logic [7:0] A_CHGV  = 8'h24;
    localparam logic [7:0] A_LEVEL = 8'h28;

    // pack setup word fields
    localparam int P_THERM  = 0;
    localparam int P_OFF_EN = 1;
    localparam int P_POL    = 2;
    localparam int P_DRIVE  = 3;
    localparam int P_RELOAD = 4;
    localparam int P_SLEEP  = 5;
    localparam int P_GND    = 11;
    localparam logic [15:0] PACK_RST = 16'h0177;

    // control state word fields and subcommands
    localparam int C_ACTIVE = 15;
    localparam int C_ARMED  = 7;
    localparam logic [15:0] SUB_ARM    = 16'h0013;
    localparam logic [15:0] SUB_DISARM = 16'h0014;

    // termination qualification
    localparam logic [1:0]  TAPER_WINDOWS = 2'h2;
    localparam logic [15:0] CAP_MIN_CENTI = 16'h0019; // 0.25 mAh in 0.01 mAh units
    localparam logic signed [7:0] LEVEL_OFF = -8'sd1;

    // configuration reset values
    localparam logic [31:0] OT_RST  = 32'h0002_2D37;
    localparam logic [31:0] INH_RST = 32'h0005_2D00;
    localparam logic [31:0] SUS_RST = 32'h0000_37F6;
    localparam logic [31:0] CUR_RST = 32'h003C_0064;
    localparam logic [31:0] TAP_RST = 32'h0064_0064;
    localparam logic [31:0] CHV_RST = 32'h0000_1068;
    localparam logic [31:0] LVL_RST = 32'h0000_FFFF;

    typedef enum logic [1:0] {M_NORMAL, M_SLEEP, M_HIBERNATE} gsf_mode_t;

    typedef struct packed {
        logic terminated;
        logic full;
        logic term_alarm;
        logic chg;
        logic charge_pause_flag;
        logic charge_hold_flag;
        logic discharge_overtemp_flag;
        logic charge_overtemp_flag;
    } gsf_flags_t;
endpackage

// file: logic/gsf_top.sv
/*
 gauge shutdown and status flags: power-off pin, pack setup word, thermal and charge flags,
 power mode sequencing. assumes measurements arrive synchronous to i_clk, already averaged.
*/
`timescale 1ns/100ps
`default_nettype none
module gsf_top
    import gsf_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYCLES
)(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic [7:0]        i_addr,
    input  wire logic [31:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [31:0]       o_rdata,
    input  wire logic [15:0]       i_pack_boot,
    input  wire logic signed [7:0] i_temp_ext,
    input  wire logic signed [7:0] i_temp_int,
    input  wire logic signed [15:0] i_mean_current,
    input  wire logic [15:0]       i_voltage,
    input  wire logic [15:0]       i_cap_delta,
    input  wire logic              i_window_tick,
    input  wire logic [7:0]        i_soc,
    input  wire logic [15:0]       i_full_cap,
    input  wire logic              i_sleep_ok,
    input  wire logic              i_hib_request,
    input  wire logic              i_comm_activity,
    output logic                   o_power_off_pin,
    output logic                   o_power_off_pin_oe,
    output logic                   o_adc_ground_select,
    output logic                   o_thermal_source_select,
    output gsf_mode_t              o_mode,
    output gsf_flags_t             o_flags,
    output logic                   o_cap_reload,
    output logic      [15:0]       o_remaining_cap
);
    logic [15:0] pack_q;
    logic [31:0] cot_q, dot_q, inh_q, sus_q, cur_q, tap_q, chv_q, lvl_q;
    logic        boot_q, drive_q, armed_q;
    gsf_mode_t   mode_q, mode_d;
    gsf_flags_t  fl_q;
    logic [1:0]  taper_cnt_q;
    logic [7:0]  cot_cnt_q, dot_cnt_q;
    logic [31:0] sec_cnt_q, rdata_q;
    logic        reload_q;
    logic [15:0] rem_q;

    // write decode
    wire wr_pack = i_wr && i_addr == A_PACK;
    wire wr_ctrl = i_wr && i_addr == A_CTRL;
    wire sub_arm = wr_ctrl && i_wdata[15:0] == SUB_ARM;
    wire sub_dis = wr_ctrl && i_wdata[15:0] == SUB_DISARM;
    wire en_load = (wr_pack && i_wdata[P_OFF_EN]) || (!boot_q && i_pack_boot[P_OFF_EN]);

    // second tick from a divider, shared by both over-temperature timers
    wire sec_tick = sec_cnt_q == SEC_CYC - 1;

    // selected temperature and thresholds
    wire signed [7:0] temp = pack_q[P_THERM] ? i_temp_ext : i_temp_int;
    wire signed [7:0] cot_lim = cot_q[7:0];
    wire signed [7:0] cot_rec = cot_q[15:8];
    wire [7:0]        cot_t   = cot_q[23:16];
    wire signed [7:0] dot_lim = dot_q[7:0];
    wire signed [7:0] dot_rec = dot_q[15:8];
    wire [7:0]        dot_t   = dot_q[23:16];
    wire signed [15:0] chg_thr = cur_q[15:0];
    wire signed [16:0] dsg_thr = -$signed({1'b0, cur_q[31:16]});
    wire charging = i_mean_current > chg_thr;
    wire discharging = $signed({i_mean_current[15], i_mean_current}) <= dsg_thr;

    // over-temperature qualifiers
    wire cot_cond = charging && temp >= cot_lim;
    wire dot_cond = discharging && temp >= dot_lim;
    wire cot_set = cot_cond && cot_t != 8'h00 && cot_cnt_q >= cot_t;
    wire dot_set = dot_cond && dot_t != 8'h00 && dot_cnt_q >= dot_t;

    // hold and pause windows, widened to 9 bits so hysteresis up to 128 cannot wrap
    wire signed [8:0] hys = $signed({1'b0, inh_q[23:16]});
    wire signed [8:0] t9 = 9'(temp);
    wire signed [8:0] inh_lo = 9'($signed(inh_q[7:0]));
    wire signed [8:0] inh_hi = 9'($signed(inh_q[15:8]));
    wire signed [8:0] sus_lo = 9'($signed(sus_q[7:0]));
    wire signed [8:0] sus_hi = 9'($signed(sus_q[15:8]));
    wire back_in = t9 >= inh_lo + hys && t9 <= inh_hi - hys;
    wire hold_set = t9 < inh_lo || t9 > inh_hi;
    wire pause_set = t9 < sus_lo || t9 > sus_hi;

    // taper window qualification
    wire [16:0] v_min = {1'b0, chv_q[15:0]} - {1'b0, tap_q[31:16]};
    wire taper_ok = i_mean_current < $signed(tap_q[15:0]) && i_cap_delta > CAP_MIN_CENTI
                    && !v_min[16] && i_voltage > v_min[15:0];
    wire taper_done = i_window_tick && taper_ok && taper_cnt_q == TAPER_WINDOWS - 2'h1;
    wire signed [7:0] tca = lvl_q[7:0];
    wire signed [7:0] fcs = lvl_q[15:8];
    wire tca_hit = tca != LEVEL_OFF && $signed({1'b0, i_soc}) >= 9'(tca);
    wire fc_hit = fcs != LEVEL_OFF && $signed({1'b0, i_soc}) >= 9'(fcs);

    // pin state: shutdown only while armed in hibernate, floating until boot
    wire shut = armed_q && mode_q == M_HIBERNATE;
    wire pin_lvl = shut ? pack_q[P_POL] : !pack_q[P_POL];
    wire wake = i_comm_activity || i_wr || i_rd; // bus traffic is line activity too

    // power mode sequencing
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            M_NORMAL:
            begin
                if (i_hib_request)
                    mode_d = M_HIBERNATE;
                else if (i_sleep_ok && pack_q[P_SLEEP])
                    mode_d = M_SLEEP;
            end
            M_SLEEP:
            begin
                if (i_hib_request)
                    mode_d = M_HIBERNATE;
                else if (!i_sleep_ok || !pack_q[P_SLEEP] || wake)
                    mode_d = M_NORMAL;
            end
            M_HIBERNATE:
            begin
                if (wake)
                    mode_d = M_NORMAL;
            end
            default:
                mode_d = M_NORMAL;
        endcase
    end

    // pack word: boot image taken once after release, drive style latched only then
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            boot_q  <= 1'b0;
            pack_q  <= PACK_RST;
            drive_q <= 1'b0;
        end
        else if (!boot_q)
        begin
            boot_q  <= 1'b1;
            pack_q  <= i_pack_boot;
            drive_q <= i_pack_boot[P_DRIVE];
        end
        else if (wr_pack)
            pack_q <= i_wdata[15:0];
    end

    // shutdown arming, arm wins over disarm
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            armed_q <= 1'b1;
        else if (sub_arm || en_load)
            armed_q <= 1'b1;
        else if (sub_dis)
            armed_q <= 1'b0;
    end

    // threshold registers
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cot_q <= OT_RST;
            dot_q <= OT_RST;
            inh_q <= INH_RST;
            sus_q <= SUS_RST;
            cur_q <= CUR_RST;
            tap_q <= TAP_RST;
            chv_q <= CHV_RST;
            lvl_q <= LVL_RST;
        end
        else if (i_wr)
        begin
            if (i_addr == A_COT) cot_q <= i_wdata;
            if (i_addr == A_DOT) dot_q <= i_wdata;
            if (i_addr == A_INH) inh_q <= i_wdata;
            if (i_addr == A_SUSP) sus_q <= i_wdata;
            if (i_addr == A_CUR) cur_q <= i_wdata;
            if (i_addr == A_TAPER) tap_q <= i_wdata;
            if (i_addr == A_CHGV) chv_q <= i_wdata;
            if (i_addr == A_LEVEL) lvl_q <= i_wdata;
        end
    end

    // mode and timers
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mode_q    <= M_NORMAL;
            sec_cnt_q <= 32'h0000_0000;
            cot_cnt_q <= 8'h00;
            dot_cnt_q <= 8'h00;
        end
        else
        begin
            mode_q    <= mode_d;
            sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
            // timers saturate so a long dwell never wraps back below the limit
            if (!cot_cond) cot_cnt_q <= 8'h00;
            else if (sec_tick && cot_cnt_q != 8'hFF) cot_cnt_q <= cot_cnt_q + 8'h01;
            if (!dot_cond) dot_cnt_q <= 8'h00;
            else if (sec_tick && dot_cnt_q != 8'hFF) dot_cnt_q <= dot_cnt_q + 8'h01;
        end
    end

    // status flags: every set term beats its clear term, except chg, where the taper_done clear beats the discharging set
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            fl_q        <= '0;
            fl_q.chg    <= 1'b1;
            taper_cnt_q <= 2'h0;
            reload_q    <= 1'b0;
            rem_q       <= 16'h0000;
        end
        else
        begin
            if (cot_set) fl_q.charge_overtemp_flag <= 1'b1;
            else if (temp <= cot_rec) fl_q.charge_overtemp_flag <= 1'b0;
            if (dot_set) fl_q.discharge_overtemp_flag <= 1'b1;
            else if (temp <= dot_rec) fl_q.discharge_overtemp_flag <= 1'b0;
            if (hold_set) fl_q.charge_hold_flag <= 1'b1;
            else if (back_in) fl_q.charge_hold_flag <= 1'b0;
            if (pause_set) fl_q.charge_pause_flag <= 1'b1;
            else if (back_in) fl_q.charge_pause_flag <= 1'b0;
            if (i_window_tick)
                taper_cnt_q <= taper_done ? 2'h0 : (taper_ok ? taper_cnt_q + 2'h1 : 2'h0);
            // termination clears charge; discharge rearms chg and terminated, and full and term_alarm unless a level hit holds them
            if (taper_done) fl_q.chg <= 1'b0;
            else if (discharging) fl_q.chg <= 1'b1;
            if (taper_done || tca_hit) fl_q.term_alarm <= 1'b1;
            else if (discharging) fl_q.term_alarm <= 1'b0;
            if (taper_done || fc_hit) fl_q.full <= 1'b1;
            else if (discharging) fl_q.full <= 1'b0;
            if (taper_done) fl_q.terminated <= 1'b1;
            else if (discharging) fl_q.terminated <= 1'b0;
            reload_q <= taper_done && pack_q[P_RELOAD];
            if (taper_done && pack_q[P_RELOAD]) rem_q <= i_full_cap;
        end
    end

    // read data, one cycle after the strobe and zero otherwise
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            rdata_q <= 32'h0000_0000;
        else if (!i_rd)
            rdata_q <= 32'h0000_0000;
        else
        begin
            unique case (i_addr)
                A_PACK:  rdata_q <= {16'h0000, pack_q};
                A_CTRL:  rdata_q <= {16'h0000, shut, 7'h00, armed_q, 7'h00};
                A_FLAGS: rdata_q <= {24'h0000_00, fl_q};
                A_COT:   rdata_q <= cot_q;
                A_DOT:   rdata_q <= dot_q;
                A_INH:   rdata_q <= inh_q;
                A_SUSP:  rdata_q <= sus_q;
                A_CUR:   rdata_q <= cur_q;
                A_TAPER: rdata_q <= tap_q;
                A_CHGV:  rdata_q <= chv_q;
                A_LEVEL: rdata_q <= lvl_q;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // outputs; the pin floats before boot and for a high level without push-pull
    assign o_power_off_pin    = boot_q && pin_lvl;
    assign o_power_off_pin_oe = boot_q && (!pin_lvl || drive_q);
    assign o_adc_ground_select     = pack_q[P_GND];
    assign o_thermal_source_select = pack_q[P_THERM];
    assign o_mode       = mode_q;
    assign o_flags      = fl_q;
    assign o_rdata      = rdata_q;
    assign o_cap_reload = reload_q;
    assign o_remaining_cap = rem_q;
endmodule
`default_nettype wire

// file: tb/gsf_sva.sv
/*
 gsf_sva: port-level checks of the power-off pin, mode, bus and flag timing of gsf_top.
 assumes it is bound onto gsf_top, with one clock and an async active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module gsf_sva
    import gsf_pkg::*;
#(
    parameter int unsigned SEC_CYC = 20
)(
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [15:0] i_full_cap,
    input wire logic        i_hib_request,
    input wire logic        i_comm_activity,
    input wire logic        o_power_off_pin,
    input wire logic        o_power_off_pin_oe,
    input wire logic        o_adc_ground_select,
    input wire logic        o_thermal_source_select,
    input wire gsf_mode_t   o_mode,
    input wire gsf_flags_t  o_flags,
    input wire logic        o_cap_reload,
    input wire logic [15:0] o_remaining_cap
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    // wake step: hibernate sees traffic on the bus or comm lines
    sequence wake_s;
        o_mode == M_HIBERNATE && (i_comm_activity || i_wr || i_rd);
    endsequence
    // quiet step: awake two samples, no write, boot latch long done
    sequence quiet_s;
        o_mode != M_HIBERNATE && $past(o_mode) != M_HIBERNATE && !$past(i_wr) && $past(i_resetn, 2);
    endsequence

    reset_float_a: assert property ($rose(i_resetn) |-> !o_power_off_pin_oe)
        else $error("power-off pin driven at reset release");
    hib_exit_a: assert property (wake_s |=> o_mode == M_NORMAL)
        else $error("hibernate not left after activity");
    hib_entry_a: assert property
        (o_mode == M_NORMAL && i_hib_request && !(i_comm_activity || i_wr || i_rd) |=> o_mode == M_HIBERNATE)
        else $error("hibernate request not taken");
    pin_hold_a: assert property (quiet_s |-> $stable(o_power_off_pin) && $stable(o_power_off_pin_oe))
        else $error("power-off pin moved outside hibernate");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside answer cycle");
    ground_sel_a: assert property (i_wr && i_addr == A_PACK |=> o_adc_ground_select == $past(i_wdata[11]))
        else $error("ground select does not follow pack write");
    temp_sel_a: assert property (i_wr && i_addr == A_PACK |=> o_thermal_source_select == $past(i_wdata[0]))
        else $error("thermal source does not follow pack write");
    reload_pulse_a: assert property
        ($rose(o_cap_reload) |-> o_remaining_cap == $past(i_full_cap) ##1 !o_cap_reload)
        else $error("capacity reload wrong");
    term_flags_a: assert property
        ($rose(o_flags.terminated) |-> !o_flags.chg && o_flags.full && o_flags.term_alarm)
        else $error("termination flags inconsistent");
endmodule

bind gsf_top gsf_sva #(.SEC_CYC(SEC_CYC)) u_sva (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_full_cap(i_full_cap), .i_hib_request(i_hib_request),
    .i_comm_activity(i_comm_activity), .o_power_off_pin(o_power_off_pin),
    .o_power_off_pin_oe(o_power_off_pin_oe), .o_adc_ground_select(o_adc_ground_select),
    .o_thermal_source_select(o_thermal_source_select), .o_mode(o_mode), .o_flags(o_flags),
    .o_cap_reload(o_cap_reload), .o_remaining_cap(o_remaining_cap)
);
`default_nettype wire

// file: tb/gsf_host.sv
/*
 gsf_host: host processor model driving the register strobe port.
 assumes one-cycle strobes, no wait states, read data in the cycle after.
*/
`timescale 1ns/100ps
`default_nettype none
module gsf_host (
    input  wire logic  i_clk,
    output logic [7:0]  o_addr,
    output logic [31:0] o_wdata,
    output logic        o_wr,
    output logic        o_rd
);
    // idle bus from time zero
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // subcommands are plain writes to the control word
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask

    // gap of one cycle between calls keeps each strobe single-driven
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
/*
 tb: self-checking bench for gsf_top, host model on the register port.
 assumes gsf_pkg, gsf_host and gsf_sva compiled first; 50 ns clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
    import gsf_pkg::*;
    logic               clk;
    logic               resetn;
    logic               wr, rd, rd_seen, pin, pin_oe, gnd, tsel, reload, slp;
    logic [2:0]         pls;
    logic [7:0]         addr, soc;
    logic [31:0]        wdata, rdata;
    logic signed [7:0]  temp;
    logic signed [15:0] cur;
    logic [15:0]        volt, dcap, fcap, rcap, boot;
    gsf_mode_t          mode;
    gsf_flags_t         flags;
    logic [31:0]        exp_q[$];
    int                 n_errors = 0;
    int                 checks = 0;

    gsf_host u_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

    gsf_top #(.SEC_CYC(20)) u_dut (
        .i_clk(clk), .i_resetn(resetn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_pack_boot(boot), .i_temp_ext(temp), .i_temp_int(8'sd20),
        .i_mean_current(cur), .i_voltage(volt), .i_cap_delta(dcap), .i_window_tick(pls[2]),
        .i_soc(soc), .i_full_cap(fcap), .i_sleep_ok(slp), .i_hib_request(pls[0]),
        .i_comm_activity(pls[1]), .o_power_off_pin(pin), .o_power_off_pin_oe(pin_oe),
        .o_adc_ground_select(gnd), .o_thermal_source_select(tsel), .o_mode(mode),
        .o_flags(flags), .o_cap_reload(reload), .o_remaining_cap(rcap)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmpb(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // note the expected word, then let the host read it
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask
    // bit 0 hibernate request, 1 comm activity, 2 taper window end
    task automatic pulse(input int b);
        @(posedge clk);
        pls[b] <= 1'b1;
        @(posedge clk);
        pls[b] <= 1'b0;
        @(negedge clk);
    endtask
    task automatic env(input logic signed [7:0] t, input logic signed [15:0] c);
        @(posedge clk);
        temp <= t;
        cur <= c;
        repeat (3) @(negedge clk);
    endtask
    // bounded wait; over-temperature needs whole seconds of 20 cycles
    task automatic wait_flag(input int b, input logic v);
        for (int i = 0; i < 300 && flags[b] !== v; i++) @(posedge clk);
        @(negedge clk);
    endtask

    // read answers stand only in the cycle after the strobe
    always @(posedge clk) rd_seen <= rd;
    always @(negedge clk)
        if (rd_seen === 1'b1)
            cmp("rdata", exp_q.pop_front(), rdata);

    // whole sequence needs under 3000 cycles; 6000 is a hang
    initial
    begin
        #300_000;
        n_errors++;
        give_verdict();
    end

    initial
    begin
        resetn = 1'b0;
        pls = 3'h0;
        boot = 16'h0177;
        slp = 1'b0;
        soc = 8'h64;
        temp = 8'sd25;
        cur = 16'sd0;
        volt = 16'h1036;
        void'($urandom(14));
        fcap = 16'($urandom());
        dcap = 16'(26 + $urandom() % 900);
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        rdx(A_PACK, 32'h0000_0177);
        rdx(A_CTRL, 32'h0000_0080);
        rdx(8'h3C, 32'h0000_0000);
        @(negedge clk);
        cmpb("pin", 1'b0, pin);
        cmpb("pin_oe", 1'b1, pin_oe);
        pulse(0);
        cmpb("pin", 1'b1, pin);
        cmpb("pin_oe", 1'b0, pin_oe);
        pulse(1);
        cmpb("pin", 1'b0, pin);
        u_host.wr(A_CTRL, 32'h0000_0014);
        pulse(0);
        cmpb("pin", 1'b0, pin);
        rdx(A_CTRL, 32'h0000_0000);
        u_host.wr(A_CTRL, 32'h0000_0013);
        rdx(A_CTRL, 32'h0000_0080);
        u_host.wr(A_CTRL, 32'h0000_0014);
        u_host.wr(A_PACK, 32'h0000_097B);
        rdx(A_CTRL, 32'h0000_0080);
        @(negedge clk);
        cmpb("pin", 1'b1, pin);
        cmpb("pin_oe", 1'b0, pin_oe);
        cmpb("gnd", 1'b1, gnd);
        pulse(0);
        cmpb("pin", 1'b0, pin);
        cmpb("pin_oe", 1'b1, pin_oe);
        rdx(A_CTRL, 32'h0000_8080);
        @(negedge clk);
        cmpb("pin", 1'b1, pin);
        u_host.wr(A_PACK, 32'h0000_0976);
        @(negedge clk);
        cmpb("tsel", 1'b0, tsel);
        u_host.wr(A_PACK, 32'h0000_0177);
        env(8'sd60, 16'sd200);
        wait_flag(0, 1'b1);
        cmpb("charge_ot", 1'b1, flags.charge_overtemp_flag);
        cmpb("hold", 1'b1, flags.charge_hold_flag);
        cmpb("pause", 1'b1, flags.charge_pause_flag);
        env(8'sd42, 16'sd200);
        cmpb("charge_ot", 1'b0, flags.charge_overtemp_flag);
        cmpb("hold", 1'b1, flags.charge_hold_flag);
        cmpb("pause", 1'b1, flags.charge_pause_flag);
        env(8'sd40, 16'sd200);
        cmpb("hold", 1'b0, flags.charge_hold_flag);
        cmpb("pause", 1'b0, flags.charge_pause_flag);
        env(8'sd60, -16'sd60);
        wait_flag(1, 1'b1);
        cmpb("discharge_ot", 1'b1, flags.discharge_overtemp_flag);
        env(8'sd45, -16'sd60);
        cmpb("discharge_ot", 1'b0, flags.discharge_overtemp_flag);
        u_host.wr(A_DOT, 32'h0000_2D37);
        env(8'sd60, -16'sd60);
        wait_flag(1, 1'b1);
        cmpb("discharge_ot", 1'b0, flags.discharge_overtemp_flag);
        env(8'sd25, 16'sd50);
        cmpb("full", 1'b0, flags.full);
        cmpb("alarm", 1'b0, flags.term_alarm);
        pulse(2);
        cmpb("chg", 1'b1, flags.chg);
        pulse(2);
        cmpb("chg", 1'b0, flags.chg);
        cmpb("full", 1'b1, flags.full);
        cmpb("alarm", 1'b1, flags.term_alarm);
        cmpb("terminated", 1'b1, flags.terminated);
        cmpb("reload", 1'b1, reload);
        @(negedge clk);
        cmp("rcap", {16'h0000, fcap}, {16'h0000, rcap});
        cmpb("reload", 1'b0, reload);
        // sleep entry and exit; armed, yet the pin keeps its normal level there
        @(posedge clk);
        slp <= 1'b1;
        repeat (2) @(negedge clk);
        cmp("mode", 32'(M_SLEEP), 32'(mode));
        cmpb("pin", 1'b0, pin);
        @(posedge clk);
        slp <= 1'b0;
        repeat (2) @(negedge clk);
        cmp("mode", 32'(M_NORMAL), 32'(mode));
        // second power-on with a push-pull boot image: drive style only lands here
        @(posedge clk);
        resetn <= 1'b0;
        boot <= 16'h017F;
        @(negedge clk);
        cmpb("pin_oe", 1'b0, pin_oe);
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        pulse(0);
        cmpb("pin", 1'b1, pin);
        cmpb("pin_oe", 1'b1, pin_oe);
        repeat (3) @(negedge clk);
        give_verdict();
    end
endmodule
`default_nettype wire
